/* rtl/mdu_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef MDU_REGS_SVH
`define MDU_REGS_SVH

// =====================================================================
// Byte bus map of the arithmetic unit
`define MDU_LAST_BYTE_ADDR 3'h5
`define MDU_STATUS_ADDR    3'h6
`define MDU_ERR_BIT        7
`define MDU_OV_BIT         6
`define MDU_ERR_RST        1'h0
`define MDU_OV_RST         1'h0
`define MDU_PROD_MAX       32'h0000_FFFF

// =====================================================================
// Calculation time in system clock periods, one clock per period
`define MDU_DIV32_TSYS     5'h11
`define MDU_DIV16_TSYS     5'h09
`define MDU_MUL_TSYS       5'h0B
`define MDU_DIV32_CYCLES   (`MDU_DIV32_TSYS)
`define MDU_DIV16_CYCLES   (`MDU_DIV16_TSYS)
`define MDU_MUL_CYCLES     (`MDU_MUL_TSYS)

// =====================================================================
// Controller registers on AXI4-Lite
`define CTL_OFS_CTRL       8'h00
`define CTL_OFS_OPA        8'h04
`define CTL_OFS_OPB        8'h08
`define CTL_OFS_STAT       8'h0C
`define CTL_OFS_RES0       8'h10
`define CTL_OFS_RES1       8'h14
`define CTL_OP_LSB         0
`define CTL_START_BIT      8
`define CTL_ST_BUSY_BIT    0
`define CTL_ST_DONE_BIT    1
`define CTL_ST_ERR_BIT     2
`define CTL_ST_OV_BIT      3
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

/* rtl/mdu_pkg.sv */
// Types shared by the arithmetic unit and its controller
package mdu_pkg;

   // ==================================================================
   // Operation selected by the write order
   typedef enum logic [1:0] {
      OP_DIV32 = 2'h0,
      OP_DIV16 = 2'h1,
      OP_MUL   = 2'h2
   } op_t;

   // ==================================================================
   // Write order tracker, named by the byte registers seen so far
   typedef enum logic [8:0] {
      SQ_IDLE   = 9'h001,
      SQ_B0     = 9'h002,
      SQ_B01    = 9'h004,
      SQ_B012   = 9'h008,
      SQ_B0123  = 9'h010,
      SQ_B01234 = 9'h020,
      SQ_B014   = 9'h040,
      SQ_B04    = 9'h080,
      SQ_B041   = 9'h100
   } seq_t;

   typedef struct packed {
      seq_t            seq;
      op_t             op;
      logic            busy;
      logic [4:0]      cnt;
      logic [5:0][7:0] bytes;
      logic            err;
      logic            ov;
      logic [7:0]      rdata;
   } dev_state_t;

   // ==================================================================
   // Controller sequencer
   typedef enum logic [8:0] {
      H_IDLE = 9'h001,
      H_WR   = 9'h002,
      H_WAIT = 9'h004,
      H_STAT = 9'h008,
      H_SGAP = 9'h010,
      H_SCHK = 9'h020,
      H_RD   = 9'h040,
      H_RGAP = 9'h080,
      H_RCAP = 9'h100
   } hst_t;

   typedef struct packed {
      hst_t            st;
      op_t             op;
      logic [2:0]      step;
      logic [4:0]      wcnt;
      logic [31:0]     opa;
      logic [15:0]     opb;
      logic [5:0][7:0] res;
      logic            done;
      logic            err;
      logic            ov;
      logic            aw_got;
      logic [7:0]      awaddr;
      logic            w_got;
      logic [31:0]     wdata;
      logic [3:0]      wstrb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic            wr_en;
      logic            rd_en;
      logic [2:0]      addr;
      logic [7:0]      bdata;
   } host_state_t;

endpackage : mdu_pkg

/* rtl/mdu_byte_if.sv */
// Byte register bus between the controller and the arithmetic unit
`timescale 1ns/10ps
interface mdu_byte_if;
   logic       wr_en;
   logic       rd_en;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport dev (input wr_en, input rd_en, input addr, input wdata,
                output rdata);
   modport ctl (output wr_en, output rd_en, output addr, output wdata,
                input rdata);
endinterface : mdu_byte_if

/* rtl/multiply_divide_unit.sv */
// Byte-mapped multiply/divide unit, selected by operand write order
//
// Functional notes
// RQ1: 16x16 multiplier, 32/16 and 16/16 divider
// RQ2: Bytes 0..5 in order select 32/16 divide
// RQ3: Dividend in bytes 0-3, divisor 4-5
// RQ4: Bytes 0,1,4,5 select 16/16 divide
// RQ5: Bytes 0,4,1,5 select multiplication
// RQ6: Host writes low byte before high byte
// RQ7: Start only on byte 5 ending valid order
// RQ8: Gaps between order writes are harmless
// RQ9: Busy 17, 9 or 11 clocks
// RQ10: Host avoids byte registers while busy
// RQ11: Byte access while busy sets error
// RQ12: Status read after completion clears error
// RQ13: Overflow on product above FFFF or zero divisor
// RQ14: Overflow refreshed at every completion
// RQ15: Host checks status before reading results
// RQ16: 32/16 quotient bytes 0-3, remainder 4-5
// RQ17: 16/16 quotient bytes 0-1, remainder 4-5
// RQ18: Product in bytes 0-3, byte 0 lowest
// RQ19: Gaps between result reads are harmless
// RQ20: Host never idles during a calculation
// RQ21: Status bits 5..0 zero, flags reset clear
// RQ22: Broken order discarded, restart needs byte 0
`timescale 1ns/10ps
`include "mdu_regs.svh"

module multiply_divide_unit
   import mdu_pkg::*;
(
   input  wire logic  I_REF_CLK,
   input  wire logic  I_RST_N,
   mdu_byte_if.dev    BUS,
   output wire logic  O_BUSY,
   output wire logic  O_ERR,
   output wire logic  O_OVERFLOW
);

   dev_state_t s;
   dev_state_t n;

   // ==================================================================
   // Next state
   always_comb begin
      logic        acc_op;
      logic        byte_wr;
      logic [2:0]  a;
      logic [15:0] dvs;
      logic [31:0] dvd;
      logic [31:0] quo;
      logic [31:0] rem;
      logic [31:0] prod;
      seq_t        nseq;
      n       = s;
      a       = BUS.addr;
      acc_op  = (BUS.wr_en || BUS.rd_en) && (a <= `MDU_LAST_BYTE_ADDR);
      byte_wr = BUS.wr_en && (a <= `MDU_LAST_BYTE_ADDR);
      nseq    = SQ_IDLE;
      dvs     = {s.bytes[5], s.bytes[4]};                       // [RQ3]
      dvd     = {s.bytes[3], s.bytes[2], s.bytes[1], s.bytes[0]};
      if (s.op == OP_DIV16) begin
         dvd = {16'h0000, s.bytes[1], s.bytes[0]};              // [RQ4]
      end
      quo     = 32'h0000_0000;
      rem     = 32'h0000_0000;
      // Guarded so a zero divisor never feeds the divider
      if (dvs != 16'h0000) begin
         quo = dvd / {16'h0000, dvs};                           // [RQ1]
         rem = dvd % {16'h0000, dvs};
      end
      prod    = {16'h0000, s.bytes[1], s.bytes[0]} *
                {16'h0000, dvs};                                // [RQ1]

      // Read data; stale bytes are returned while busy
      if (BUS.rd_en) begin
         if (a <= `MDU_LAST_BYTE_ADDR) begin
            n.rdata = s.bytes[a];                               // [RQ19]
         end else if (a == `MDU_STATUS_ADDR) begin
            n.rdata = 8'h00;                                    // [RQ21]
            n.rdata[`MDU_ERR_BIT] = s.err;
            n.rdata[`MDU_OV_BIT]  = s.ov;
         end else begin
            n.rdata = 8'h00;
         end
      end

      if (s.busy) begin
         // Byte register accesses during a run are flagged and writes dropped
         if (acc_op) begin
            n.err = 1'b1;                                       // [RQ11]
         end
         if (s.cnt == 5'h01) begin
            n.busy = 1'b0;                                      // [RQ9]
            n.ov   = (dvs == 16'h0000);                 // [RQ13] [RQ14]
            unique case (s.op)
               OP_MUL: begin
                  n.bytes[3:0] = prod;                          // [RQ18]
                  n.ov         = (prod > `MDU_PROD_MAX);        // [RQ13]
               end
               OP_DIV16: begin
                  if (dvs != 16'h0000) begin
                     n.bytes[1:0] = quo[15:0];                  // [RQ17]
                     n.bytes[5:4] = rem[15:0];
                  end
               end
               OP_DIV32: begin
                  if (dvs != 16'h0000) begin
                     n.bytes[3:0] = quo;                        // [RQ16]
                     n.bytes[5:4] = rem[15:0];
                  end
               end
               default: begin
                  n.ov = 1'b0;
               end
            endcase
         end else begin
            n.cnt = s.cnt - 5'h01;
         end
      end else begin
         if (BUS.rd_en && (a == `MDU_STATUS_ADDR) && s.err) begin
            n.err = 1'b0;                                       // [RQ12]
         end
         if (byte_wr) begin
            n.bytes[a] = BUS.wdata;
            // Any byte 0 write restarts tracking; other breaks discard
            if (a == 3'h0) begin
               nseq = SQ_B0;                                    // [RQ22]
            end
            unique case (s.seq)
               SQ_B0: begin
                  if (a == 3'h1) begin
                     nseq = SQ_B01;
                  end else if (a == 3'h4) begin
                     nseq = SQ_B04;                             // [RQ5]
                  end
               end
               SQ_B01: begin
                  if (a == 3'h2) begin
                     nseq = SQ_B012;                            // [RQ2]
                  end else if (a == 3'h4) begin
                     nseq = SQ_B014;                            // [RQ4]
                  end
               end
               SQ_B012: begin
                  if (a == 3'h3) begin
                     nseq = SQ_B0123;
                  end
               end
               SQ_B0123: begin
                  if (a == 3'h4) begin
                     nseq = SQ_B01234;
                  end
               end
               SQ_B04: begin
                  if (a == 3'h1) begin
                     nseq = SQ_B041;
                  end
               end
               SQ_B01234: begin
                  if (a == 3'h5) begin
                     n.busy = 1'b1;                             // [RQ7]
                     n.op   = OP_DIV32;                         // [RQ2]
                     n.cnt  = `MDU_DIV32_CYCLES;                // [RQ9]
                  end
               end
               SQ_B014: begin
                  if (a == 3'h5) begin
                     n.busy = 1'b1;                             // [RQ7]
                     n.op   = OP_DIV16;                         // [RQ4]
                     n.cnt  = `MDU_DIV16_CYCLES;                // [RQ9]
                  end
               end
               SQ_B041: begin
                  if (a == 3'h5) begin
                     n.busy = 1'b1;                             // [RQ7]
                     n.op   = OP_MUL;                           // [RQ5]
                     n.cnt  = `MDU_MUL_CYCLES;                  // [RQ9]
                  end
               end
               default: begin
               end
            endcase
            n.seq = nseq;
         end
         // Reads and idle cycles leave the tracker alone
      end                                                       // [RQ8]
   end

   // ==================================================================
   // State register
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         s <= '{seq:   SQ_IDLE,
                op:    OP_DIV32,
                busy:  1'b0,
                cnt:   5'h00,
                bytes: 48'h0000_0000_0000,
                err:   `MDU_ERR_RST,                            // [RQ21]
                ov:    `MDU_OV_RST,
                rdata: 8'h00};
      end else begin
         s <= n;
      end
   end

   assign BUS.rdata  = s.rdata;
   assign O_BUSY     = s.busy;
   assign O_ERR      = s.err;
   assign O_OVERFLOW = s.ov;

endmodule : multiply_divide_unit

/* rtl/mdu_controller.sv */
// AXI4-Lite controller that drives the arithmetic unit byte bus
`timescale 1ns/10ps
`include "mdu_regs.svh"

module mdu_controller
   import mdu_pkg::*;
(
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST_N,
   mdu_byte_if.ctl          BUS,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output wire logic        O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output wire logic        O_WREADY,
   output wire logic [1:0]  O_BRESP,
   output wire logic        O_BVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output wire logic        O_ARREADY,
   output wire logic [31:0] O_RDATA,
   output wire logic [1:0]  O_RRESP,
   output wire logic        O_RVALID,
   input  wire logic        I_RREADY
);

   host_state_t s;
   host_state_t n;

   // Byte register visited at a step; multiply writes 0,4,1,5 but reads 0-3, other ops use one order
   function automatic logic [2:0] step_addr(op_t op, logic [2:0] st,
                                            logic rd);
      logic [2:0] r;
      r = st;
      if (op == OP_DIV16) begin
         r = (st < 3'h2) ? st : st + 3'h2;                      // [RQ4]
      end else if (op == OP_MUL && !rd) begin
         unique case (st)
            3'h1:    r = 3'h4;                                  // [RQ5]
            3'h2:    r = 3'h1;
            3'h3:    r = 3'h5;
            default: r = 3'h0;
         endcase
      end
      return r;
   endfunction : step_addr

   function automatic logic [2:0] last_step(op_t op);
      return (op == OP_DIV32) ? 3'h5 : 3'h3;
   endfunction : last_step

   // ==================================================================
   // Next state
   always_comb begin
      logic [2:0]  ba;
      logic [47:0] src;
      n       = s;
      n.wr_en = 1'b0;
      n.rd_en = 1'b0;
      src     = {s.opb, s.opa};
      ba      = step_addr(s.op, s.step, s.st != H_WR);

      // AXI write channels, taken in either order
      if (I_AWVALID && !s.aw_got && !s.bvalid) begin
         n.aw_got = 1'b1;
         n.awaddr = I_AWADDR;
      end
      if (I_WVALID && !s.w_got && !s.bvalid) begin
         n.w_got = 1'b1;
         n.wdata = I_WDATA;
         n.wstrb = I_WSTRB;
      end
      if (s.bvalid && I_BREADY) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `AXI_RESP_OKAY;
         // Operands are frozen while a run uses them
         if (s.awaddr == `CTL_OFS_OPA && s.st == H_IDLE) begin
            for (int i = 0; i < 4; i++) begin
               if (s.wstrb[i]) begin
                  n.opa[8*i +: 8] = s.wdata[8*i +: 8];
               end
            end
         end else if (s.awaddr == `CTL_OFS_OPB && s.st == H_IDLE) begin
            for (int i = 0; i < 2; i++) begin
               if (s.wstrb[i]) begin
                  n.opb[8*i +: 8] = s.wdata[8*i +: 8];
               end
            end
         end else if (s.awaddr == `CTL_OFS_CTRL) begin
            if (s.wdata[`CTL_OP_LSB +: 2] == 2'h3) begin
               n.bresp = `AXI_RESP_SLVERR;
            end else if (s.wstrb[1] && s.wdata[`CTL_START_BIT] &&
                         s.st == H_IDLE) begin
               n.op   = op_t'(s.wdata[`CTL_OP_LSB +: 2]);
               n.st   = H_WR;
               n.step = 3'h0;
               n.done = 1'b0;
               n.err  = 1'b0;
               n.ov   = 1'b0;
            end
         end else if (s.awaddr != `CTL_OFS_OPA &&
                      s.awaddr != `CTL_OFS_OPB) begin
            n.bresp = `AXI_RESP_SLVERR;
         end
      end

      // AXI read channel
      if (s.rvalid && I_RREADY) begin
         n.rvalid = 1'b0;
      end
      if (I_ARVALID && !s.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = `AXI_RESP_OKAY;
         n.rdata  = 32'h0000_0000;
         unique case (I_ARADDR)
            `CTL_OFS_CTRL: n.rdata[`CTL_OP_LSB +: 2] = s.op;
            `CTL_OFS_OPA:  n.rdata = s.opa;
            `CTL_OFS_OPB:  n.rdata[15:0] = s.opb;
            `CTL_OFS_STAT: begin
               n.rdata[`CTL_ST_BUSY_BIT] = (s.st != H_IDLE);
               n.rdata[`CTL_ST_DONE_BIT] = s.done;
               n.rdata[`CTL_ST_ERR_BIT]  = s.err;
               n.rdata[`CTL_ST_OV_BIT]   = s.ov;
            end
            `CTL_OFS_RES0: n.rdata = s.res[3:0];
            `CTL_OFS_RES1: n.rdata[15:0] = s.res[5:4];
            default:       n.rresp = `AXI_RESP_SLVERR;
         endcase
      end

      // Byte bus sequencer
      unique case (s.st)
         H_IDLE: begin
         end
         H_WR: begin
            n.wr_en = 1'b1;                                     // [RQ2]
            n.addr  = ba;
            n.bdata = src[8*ba +: 8];                     // [RQ3] [RQ6]
            n.step  = s.step + 3'h1;
            if (s.step == last_step(s.op)) begin
               n.st = H_WAIT;
               unique case (s.op)
                  OP_DIV16: n.wcnt = `MDU_DIV16_CYCLES + 5'h01;
                  OP_MUL:   n.wcnt = `MDU_MUL_CYCLES + 5'h01;
                  default:  n.wcnt = `MDU_DIV32_CYCLES + 5'h01;
               endcase
            end
         end
         H_WAIT: begin
            // Two spare clocks; no access and no idling meanwhile
            if (s.wcnt == 5'h00) begin
               n.st = H_STAT;                            // [RQ10] [RQ20]
            end else begin
               n.wcnt = s.wcnt - 5'h01;
            end
         end
         H_STAT: begin
            n.rd_en = 1'b1;
            n.addr  = `MDU_STATUS_ADDR;
            n.st    = H_SGAP;
         end
         H_SGAP: n.st = H_SCHK;
         H_SCHK: begin
            n.err  = BUS.rdata[`MDU_ERR_BIT];
            n.ov   = BUS.rdata[`MDU_OV_BIT];
            n.step = 3'h0;
            n.st   = H_RD;
            if (BUS.rdata[`MDU_ERR_BIT] || BUS.rdata[`MDU_OV_BIT]) begin
               n.st   = H_IDLE;                                 // [RQ15]
               n.done = 1'b1;
            end
         end
         H_RD: begin
            n.rd_en = 1'b1;                      // [RQ16] [RQ17] [RQ18]
            n.addr  = ba;
            n.st    = H_RGAP;
         end
         H_RGAP: n.st = H_RCAP;
         H_RCAP: begin
            n.res[ba] = BUS.rdata;
            n.step    = s.step + 3'h1;
            n.st      = H_RD;
            if (s.step == last_step(s.op)) begin
               n.st   = H_IDLE;
               n.done = 1'b1;
            end
         end
         default: n.st = H_IDLE;
      endcase
   end

   // ==================================================================
   // State register
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         s    <= '0;
         s.st <= H_IDLE;
         s.op <= OP_DIV32;
      end else begin
         s <= n;
      end
   end

   assign BUS.wr_en  = s.wr_en;
   assign BUS.rd_en  = s.rd_en;
   assign BUS.addr   = s.addr;
   assign BUS.wdata  = s.bdata;
   assign O_AWREADY  = !s.aw_got && !s.bvalid;
   assign O_WREADY   = !s.w_got && !s.bvalid;
   assign O_BVALID   = s.bvalid;
   assign O_BRESP    = s.bresp;
   assign O_ARREADY  = !s.rvalid;
   assign O_RVALID   = s.rvalid;
   assign O_RDATA    = s.rdata;
   assign O_RRESP    = s.rresp;

endmodule : mdu_controller

/* sim/mdu_chk.sv */
// Checker for the byte bus and flags of the arithmetic unit
`timescale 1ns/10ps
module mdu_chk (
   input wire logic       I_REF_CLK,
   input wire logic       I_RST_N,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] rdata,
   input wire logic       O_BUSY,
   input wire logic       O_ERR,
   input wire logic       O_OVERFLOW
);
   // ==========
   // Busy run length
   logic [4:0] run_reg;
   logic [4:0] run_next;
   logic       st_rd;
   assign st_rd = rd_en && addr == 3'h6;
   always_comb run_next = O_BUSY ? run_reg + 5'h01 : 5'h00;
   always_ff @(posedge I_REF_CLK) run_reg <= I_RST_N ? run_next : 5'h00;

   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);

   // ==========
   // Properties
   busy_len_a: assert property ($fell(O_BUSY) |->
      run_reg inside {5'h09, 5'h0B, 5'h11}) else $error("busy length");
   busy_start_a: assert property ($rose(O_BUSY) |->
      $past(wr_en && addr == 3'h5)) else $error("start without byte 5");
   busy_err_a: assert property ((wr_en || rd_en) && addr < 3'h6
      && O_BUSY |=> O_ERR) else $error("busy access not flagged");
   err_clear_a: assert property (st_rd && !O_BUSY && O_ERR
      |=> !O_ERR) else $error("error not cleared");
   err_hold_a: assert property (O_ERR && !(st_rd && !O_BUSY)
      |=> O_ERR) else $error("error dropped early");
   stat_zero_a: assert property (st_rd |=>
      rdata[5:0] == 6'h00) else $error("status low bits set");
   stat_flags_a: assert property (st_rd |=>
      rdata[7:6] == $past({O_ERR, O_OVERFLOW})) else $error("status flags");
   ov_hold_a: assert property ($changed(O_OVERFLOW) |->
      $fell(O_BUSY)) else $error("overflow moved mid run");
endmodule : mdu_chk

/* sim/sequenced_multiply_divide_unit_tb_top.sv */
// Bench joining controller and unit, driven over AXI4-Lite
`timescale 1ns/10ps
module sequenced_multiply_divide_unit_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, busy, err, ov;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [4:0]  bcnt = 5'h00;
   logic [4:0]  blen = 5'h00;
   int          fails = 0;
   int          checks_done = 0;
   int          cyc = 0;

   always #12.5 clk = ~clk;

   mdu_byte_if mdu_byte_if_i ();
   mdu_controller mdu_controller_i (.I_REF_CLK(clk), .I_RST_N(rst_n),
      .BUS(mdu_byte_if_i), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
      .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
   multiply_divide_unit multiply_divide_unit_i (.I_REF_CLK(clk),
      .I_RST_N(rst_n), .BUS(mdu_byte_if_i), .O_BUSY(busy), .O_ERR(err),
      .O_OVERFLOW(ov));
   mdu_chk mdu_chk_i (.I_REF_CLK(clk), .I_RST_N(rst_n),
      .wr_en(mdu_byte_if_i.wr_en), .rd_en(mdu_byte_if_i.rd_en),
      .addr(mdu_byte_if_i.addr), .rdata(mdu_byte_if_i.rdata),
      .O_BUSY(busy), .O_ERR(err), .O_OVERFLOW(ov));

   // ==========
   // Length of the last busy run, in clock edges
   always @(posedge clk) begin
      bcnt <= busy ? bcnt + 5'h01 : 5'h00;
      if (busy) blen <= bcnt + 5'h01;
   end

   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   // ==========
   // Bus tasks; ready is looked at mid cycle, where it is settled
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ta, tw, g;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      g = 1'b0;
      while (!g) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         g = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      // One clear edge so a following call never re-raises it at once
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic t, g;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      g = 1'b0;
      while (!g) begin
         @(negedge clk);
         t = arvalid && arready;
         g = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic get(input logic [7:0] a, input logic [31:0] k, e,
                      input string m);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d & k, e, m);
   endtask : get

   // Runs one operation and returns the status once done
   task automatic run(input logic [1:0] c, input logic [31:0] a,
                      input logic [15:0] b, output logic [31:0] s);
      logic [1:0] r;
      wr(8'h04, a, r);
      wr(8'h08, {16'h0000, b}, r);
      wr(8'h00, {30'h0000_0040, c}, r);
      chk(r, 2'h0, "start response");
      s = 32'h0000_0000;
      while (!s[1]) rd(8'h0C, s, r);
   endtask : run

   // ==========
   // Scenarios
   task automatic t_idle;
      logic [31:0] d;
      logic [1:0]  r;
      rd(8'h0C, d, r);
      chk(d, 32'h0000_0000, "status after reset");
      rd(8'h20, d, r);
      chk(r, 2'h2, "unmapped read");
      wr(8'h00, 32'h0000_0103, r);
      chk(r, 2'h2, "illegal op code");
      $display("done idle");
   endtask : t_idle

   task automatic t_mul;
      logic [31:0] s;
      run(2'h2, 32'h0000_00FF, 16'h0101, s);
      chk(s[3:1], 3'h1, "product at limit");
      chk(blen, 5'h0B, "multiply time");
      get(8'h10, '1, 32'h00FF * 32'h0101, "product");
      run(2'h2, 32'h0000_0100, 16'h0100, s);
      chk(s[3:1], 3'h5, "product overflow");
      get(8'h10, '1, 32'h0000_FFFF, "product kept");
      $display("done mul");
   endtask : t_mul

   task automatic t_div32;
      logic [31:0] s;
      run(2'h0, 32'h89AB_CDEF, 16'h1234, s);
      chk(s[3:1], 3'h1, "overflow refreshed");
      chk(blen, 5'h11, "long divide time");
      get(8'h10, '1, 32'h89AB_CDEF / 32'h1234, "quotient");
      get(8'h14, 32'h0000_FFFF, 32'h89AB_CDEF % 32'h1234, "rem");
      run(2'h0, 32'hFFFF_FFFF, 16'h0001, s);
      get(8'h10, '1, 32'hFFFF_FFFF, "full quotient");
      get(8'h14, 32'h0000_FFFF, 32'h0000_0000, "zero rem");
      $display("done div32");
   endtask : t_div32

   task automatic t_div16;
      logic [31:0] s;
      run(2'h1, 32'h0000_1111, 16'h0000, s);
      chk(s[3:1], 3'h5, "zero divisor");
      chk(blen, 5'h09, "short divide time");
      get(8'h10, '1, 32'hFFFF_FFFF, "result kept");
      run(2'h1, 32'h0000_F00D, 16'h0007, s);
      chk(s[3:1], 3'h1, "overflow cleared");
      get(8'h10, 32'h0000_FFFF, 32'h0000_F00D / 32'h7, "quot");
      get(8'h14, 32'h0000_FFFF, 32'h0000_F00D % 32'h7, "rem");
      $display("done div16");
   endtask : t_div16

   // Reset dropped while a run is under way must leave the controller status clear and operand A zero
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      wr(8'h04, 32'h0000_1234, r);
      wr(8'h00, 32'h0000_0100, r);
      repeat (5) @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h0C, d, r);
      chk(d, 32'h0000_0000, "status after mid reset");
      rd(8'h04, d, r);
      chk(d, 32'h0000_0000, "operand after mid reset");
      $display("done reset");
   endtask : t_reset

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_idle();
      t_mul();
      t_div32();
      t_div16();
      t_reset();
      report_and_stop();
   end
endmodule : sequenced_multiply_divide_unit_tb_top
